// *** itg_pkg.sv ***
package itg_pkg;
    // ======================================================
    // Register map (byte addresses, one 32-bit word each)
    // ======================================================
    localparam logic [3:0] ITG_ADDR_COUNT = 4'h0;
    localparam logic [3:0] ITG_ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ITG_ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ITG_ADDR_STATUS = 4'hC;
    localparam int ITG_ADDR_W = 4;

    // ======================================================
    // Control word field positions
    // ======================================================
    localparam int ITG_BIT_ENABLE = 15;
    localparam int ITG_BIT_STOP_IDLE = 13;
    localparam int ITG_BIT_GATE = 6;
    localparam int ITG_BIT_PS_HI = 5;
    localparam int ITG_BIT_PS_LO = 4;
    localparam int ITG_BIT_SYNC = 2;
    localparam int ITG_BIT_CLKSEL = 1;
    localparam logic [15:0] ITG_CTRL_MASK = 16'hA076;

    // ======================================================
    // Status word field positions
    // ======================================================
    localparam int ITG_BIT_FLAG = 0;
    localparam int ITG_BIT_IRQ_EN = 1;
    localparam int ITG_BIT_MATCH_SEEN = 2;
    localparam int ITG_BIT_GATE_FALL = 3;

    // ======================================================
    // Reset values
    // ======================================================
    localparam logic [15:0] ITG_RST_COUNT = 16'h0000;
    localparam logic [15:0] ITG_RST_PERIOD = 16'hFFFF;
    localparam logic [15:0] ITG_RST_CONTROL = 16'h0000;

    // ======================================================
    // Prescaler terminal counts (divide minus one)
    // ======================================================
    localparam logic [7:0] ITG_PS_DIV1 = 8'h00;
    localparam logic [7:0] ITG_PS_DIV8 = 8'h07;
    localparam logic [7:0] ITG_PS_DIV64 = 8'h3F;
    localparam logic [7:0] ITG_PS_DIV256 = 8'hFF;

    // Bus slave phases
    typedef enum logic [1:0] {ITG_BUS_IDLE, ITG_BUS_ACK} itg_bus_t;
endpackage : itg_pkg

// *** itg_edge.sv ***
`timescale 1ns/1ps
// ======================================================
// Three-stage sampler with edge pulses
// ======================================================
module itg_edge (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic raw_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    // Shift chain; only stage2 and stage3 are looked at
    always_comb begin
        next_stage1 = raw_in;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    assign level_out = stage2;
    assign rise_out = stage2 & ~stage3;
    assign fall_out = ~stage2 & stage3;
endmodule : itg_edge

// *** itg_timer.sv ***
`timescale 1ns/1ps
module itg_timer
    import itg_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Avalon-MM slave
    input wire logic [ITG_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // CPU power state
    input wire logic CPU_IDLE_IN,
    input wire logic CPU_SLEEP_IN,
    // External clock or gate pin
    input wire logic GATE_CLOCK_PIN_IN,
    // Interrupt
    output logic IRQ_OUT
);
    // ======================================================
    // State
    // ======================================================
    itg_bus_t bus_state;
    itg_bus_t next_bus_state;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [15:0] count_value;
    logic [15:0] next_count_value;
    logic [15:0] period_limit;
    logic [15:0] next_period_limit;
    logic [15:0] control_word;
    logic [15:0] next_control_word;
    logic [7:0] prescale_cnt;
    logic [7:0] next_prescale_cnt;
    logic match_event_flag;
    logic next_match_event_flag;
    logic match_event_enable;
    logic next_match_event_enable;
    logic match_seen;
    logic next_match_seen;
    logic gate_fall_seen;
    logic next_gate_fall_seen;
    logic irq;
    logic next_irq;
    logic waitreq;
    logic next_waitreq;

    // ======================================================
    // Decoded control fields
    // ======================================================
    logic counter_enable;
    logic stop_in_idle;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;

    assign counter_enable = control_word[ITG_BIT_ENABLE];
    assign stop_in_idle = control_word[ITG_BIT_STOP_IDLE];
    assign gate_accumulate_enable = control_word[ITG_BIT_GATE];
    assign prescale_select = control_word[ITG_BIT_PS_HI:ITG_BIT_PS_LO];
    assign external_sync_select = control_word[ITG_BIT_SYNC];
    assign clock_source_select = control_word[ITG_BIT_CLKSEL];

    // ======================================================
    // Pin sampling
    // ======================================================
    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    // One sampler serves both the counter edge and the gate level
    itg_edge u_pin (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .raw_in(GATE_CLOCK_PIN_IN),
        .level_out(pin_level),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // ======================================================
    // Bus access decode
    // ======================================================
    logic bus_go;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_status;
    logic rd_status;
    logic [15:0] wmask;

    // Single-cycle wait: request taken when idle, answered next edge
    assign bus_go = (bus_state == ITG_BUS_IDLE) & (AVS_READ_IN | AVS_WRITE_IN);
    assign wmask = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    assign wr_count = bus_go & AVS_WRITE_IN & (AVS_ADDRESS_IN == ITG_ADDR_COUNT);
    assign wr_period = bus_go & AVS_WRITE_IN & (AVS_ADDRESS_IN == ITG_ADDR_PERIOD);
    assign wr_control = bus_go & AVS_WRITE_IN & (AVS_ADDRESS_IN == ITG_ADDR_CONTROL);
    assign wr_status = bus_go & AVS_WRITE_IN & (AVS_ADDRESS_IN == ITG_ADDR_STATUS);
    assign rd_status = bus_go & AVS_READ_IN & (AVS_ADDRESS_IN == ITG_ADDR_STATUS);

    // ======================================================
    // Counting source selection
    // ======================================================
    logic idle_hold;
    logic sleep_ok;
    logic src_tick;
    logic ps_done;
    logic inc_tick;
    logic wrap;

    // Idle gating applies to every mode, async counter included
    assign idle_hold = CPU_IDLE_IN & stop_in_idle;
    // Only the async external counter survives sleep
    assign sleep_ok = ~CPU_SLEEP_IN
        | (counter_enable & clock_source_select & ~external_sync_select);

    // Source ticks before prescaling
    always_comb begin
        src_tick = 1'b0;
        if (clock_source_select) begin
            // Async mode is modelled on the sampled edge; a truly
            // unsynchronised path would need a second clock domain
            src_tick = pin_rise;
        end else if (gate_accumulate_enable) begin
            src_tick = pin_level;
        end else begin
            src_tick = 1'b1;
        end
    end

    // Prescaler terminal count
    always_comb begin
        ps_done = 1'b0;
        unique case (prescale_select)
            2'b00: ps_done = (prescale_cnt == ITG_PS_DIV1);
            2'b01: ps_done = (prescale_cnt == ITG_PS_DIV8);
            2'b10: ps_done = (prescale_cnt == ITG_PS_DIV64);
            2'b11: ps_done = (prescale_cnt == ITG_PS_DIV256);
        endcase
    end

    logic run;
    assign run = counter_enable & ~idle_hold & sleep_ok;
    assign inc_tick = run & src_tick & ps_done;
    assign wrap = (count_value == period_limit);

    // ======================================================
    // Prescaler next value
    // ======================================================
    always_comb begin
        next_prescale_cnt = prescale_cnt;
        // A disabled prescaler has no clock, so a count write leaves it alone
        if (wr_count & counter_enable) begin
            next_prescale_cnt = 8'h00;
        end else if (wr_control & ~AVS_WRITEDATA_IN[ITG_BIT_ENABLE]
                     & AVS_BYTEENABLE_IN[1] & counter_enable) begin
            next_prescale_cnt = 8'h00;
        end else if (run & src_tick) begin
            // Frozen while disabled: nothing else touches it then
            next_prescale_cnt = ps_done ? 8'h00 : prescale_cnt + 8'h01;
        end
    end

    // ======================================================
    // Count, period and control next values
    // ======================================================
    always_comb begin
        next_count_value = count_value;
        next_period_limit = period_limit;
        next_control_word = control_word;
        if (wr_count) begin
            next_count_value = (count_value & ~wmask)
                | (AVS_WRITEDATA_IN[15:0] & wmask);
        end else if (inc_tick) begin
            // Equality seen on this tick returns the count to zero
            next_count_value = wrap ? 16'h0000 : count_value + 16'h0001;
        end
        if (wr_period) begin
            next_period_limit = (period_limit & ~wmask) | (AVS_WRITEDATA_IN[15:0] & wmask);
        end
        if (wr_control) begin
            // The control word changes and the count is left alone; a write that clears enable also zeroes the prescaler
            next_control_word = ((control_word & ~wmask) | (AVS_WRITEDATA_IN[15:0] & wmask))
                & ITG_CTRL_MASK;
        end
    end

    // ======================================================
    // Events, flags and interrupt
    // ======================================================
    logic match_evt;
    logic gate_evt;

    assign match_evt = inc_tick & wrap;
    // Gate falling edge ends an accumulation period
    assign gate_evt = counter_enable & ~clock_source_select
        & gate_accumulate_enable & pin_fall;

    always_comb begin
        next_match_event_flag = match_event_flag;
        next_match_event_enable = match_event_enable;
        next_match_seen = match_seen;
        next_gate_fall_seen = gate_fall_seen;
        // Software clears by writing zero; a write of one is ignored
        if (wr_status & AVS_BYTEENABLE_IN[0]) begin
            if (~AVS_WRITEDATA_IN[ITG_BIT_FLAG]) begin
                next_match_event_flag = 1'b0;
            end
            next_match_event_enable = AVS_WRITEDATA_IN[ITG_BIT_IRQ_EN];
        end
        // Read of status clears the per-source sticky bits
        if (rd_status) begin
            next_match_seen = 1'b0;
            next_gate_fall_seen = 1'b0;
        end
        // Set wins over any clear in the same cycle
        if (match_evt | gate_evt) begin
            next_match_event_flag = 1'b1;
        end
        if (match_evt) begin
            next_match_seen = 1'b1;
        end
        if (gate_evt) begin
            next_gate_fall_seen = 1'b1;
        end
        next_irq = next_match_event_flag & next_match_event_enable;
    end

    // ======================================================
    // Bus answer
    // ======================================================
    always_comb begin
        next_bus_state = ITG_BUS_IDLE;
        next_waitreq = 1'b1;
        next_rdata = rdata;
        if (bus_go) begin
            next_bus_state = ITG_BUS_ACK;
            next_waitreq = 1'b0;
            next_rdata = 32'h0000_0000;
            if (AVS_READ_IN) begin
                unique case (AVS_ADDRESS_IN)
                    ITG_ADDR_COUNT: next_rdata = {16'h0000, count_value};
                    ITG_ADDR_PERIOD: next_rdata = {16'h0000, period_limit};
                    ITG_ADDR_CONTROL: next_rdata = {16'h0000, control_word};
                    ITG_ADDR_STATUS: next_rdata = {28'h0000000, gate_fall_seen,
                        match_seen, match_event_enable, match_event_flag};
                    default: next_rdata = 32'h0000_0000; // Unmapped reads zero
                endcase
            end
        end
    end

    // ======================================================
    // Registers
    // ======================================================
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            bus_state <= ITG_BUS_IDLE;
            rdata <= 32'h0000_0000;
            count_value <= ITG_RST_COUNT;
            period_limit <= ITG_RST_PERIOD;
            control_word <= ITG_RST_CONTROL;
            prescale_cnt <= 8'h00;
            match_event_flag <= 1'b0;
            match_event_enable <= 1'b0;
            match_seen <= 1'b0;
            gate_fall_seen <= 1'b0;
            irq <= 1'b0;
            waitreq <= 1'b1;
        end else begin
            bus_state <= next_bus_state;
            rdata <= next_rdata;
            count_value <= next_count_value;
            period_limit <= next_period_limit;
            control_word <= next_control_word;
            prescale_cnt <= next_prescale_cnt;
            match_event_flag <= next_match_event_flag;
            match_event_enable <= next_match_event_enable;
            match_seen <= next_match_seen;
            gate_fall_seen <= next_gate_fall_seen;
            irq <= next_irq;
            waitreq <= next_waitreq;
        end
    end

    // Waitrequest is high except in the answer cycle; own flop, no decode
    assign AVS_WAITREQUEST_OUT = waitreq;
    assign AVS_READDATA_OUT = rdata;
    assign IRQ_OUT = irq;
endmodule : itg_timer

// *** itg_timer_asserts.sv ***
`timescale 1ns/1ps
// ======================================================
// Port-level checks for the interval timer
// ======================================================
module itg_timer_asserts
    import itg_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Register bus
    input wire logic [ITG_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    // Power state, pin and interrupt
    input wire logic CPU_IDLE_IN,
    input wire logic CPU_SLEEP_IN,
    input wire logic GATE_CLOCK_PIN_IN,
    input wire logic IRQ_OUT
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // Bus handshake: fixed one-cycle answer, never spontaneous
    a_answer_bound: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> ##1 !AVS_WAITREQUEST_OUT)
        else $error("bus answer missing one cycle after request");
    a_answer_single: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");
    a_no_spurious: assert property (!(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> AVS_WAITREQUEST_OUT) else $error("answer without a request");
    // Read data: unused places and upper half read zero
    a_unmapped_zero: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN[1:0] != 2'h0 |-> AVS_READDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
        |-> AVS_READDATA_OUT[31:16] == 16'h0) else $error("upper half of read data not zero");
    a_ctrl_reserved: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN == ITG_ADDR_CONTROL |-> (AVS_READDATA_OUT[15:0] & ~ITG_CTRL_MASK) == 16'h0)
        else $error("unused control bit reads one");
    // Interrupt level follows flag and enable as last read
    a_irq_matches: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN == ITG_ADDR_STATUS |-> IRQ_OUT == (AVS_READDATA_OUT[0] && AVS_READDATA_OUT[1]))
        else $error("interrupt level disagrees with status");
    a_reset_quiet: assert property ($fell(SYS_RST_IN) |-> AVS_WAITREQUEST_OUT && !IRQ_OUT)
        else $error("bus or interrupt active right after reset");
endmodule : itg_timer_asserts

bind itg_timer itg_timer_asserts u_itg_timer_asserts (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .CPU_IDLE_IN(CPU_IDLE_IN), .CPU_SLEEP_IN(CPU_SLEEP_IN),
    .GATE_CLOCK_PIN_IN(GATE_CLOCK_PIN_IN), .IRQ_OUT(IRQ_OUT));

// *** itg_pin_model.sv ***
`timescale 1ns/1ps
// ======================================================
// External clock or gate source
// ======================================================
module itg_pin_model (
    // Clock
    input wire logic clk_in,
    // Pin
    output logic pin_out
);
    // Pin rests low between bursts, as an idle external clock would
    initial pin_out = 1'b0;

    // Burst of rising edges; a width of one gives the fastest legal pulse
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clk_in);
            pin_out <= 1'b1;
            repeat (w) @(posedge clk_in);
            pin_out <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
    endtask : pulses

    // Gate window held high for a set number of cycles
    task automatic gate(input int n);
        @(posedge clk_in);
        pin_out <= 1'b1;
        repeat (n) @(posedge clk_in);
        pin_out <= 1'b0;
    endtask : gate
endmodule : itg_pin_model

// *** tb_interval_timer16_gated.sv ***
`timescale 1ns/1ps
// ======================================================
// Self-checking bench for the interval timer
// ======================================================
module tb_interval_timer16_gated
    import itg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ITG_ADDR_W-1:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic pin;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;

    // 40 MHz clock
    initial forever #12.5 clk = ~clk;

    itg_timer u_itg_timer (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'h3),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .CPU_IDLE_IN(idle),
        .CPU_SLEEP_IN(sleep), .GATE_CLOCK_PIN_IN(pin), .IRQ_OUT(irq));
    itg_pin_model u_itg_pin_model (.clk_in(clk), .pin_out(pin));

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
            output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {16'h0, d};
        // Only the watchdog ends a wait that never sees the answer
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 16'h0, q);
    endtask : rreg
    // Range compare; an unknown never passes
    task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
            input logic [31:0] got);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            $display("unexpected %s: expected %0h..%0h, seen %0h", nm, lo, hi, got);
            err_count++;
        end
    endtask : chk

    // Reset values, unmapped read
    task automatic t_reset();
        logic [3:0] ad [5] = '{ITG_ADDR_COUNT, ITG_ADDR_PERIOD, ITG_ADDR_CONTROL,
            ITG_ADDR_STATUS, 4'h2};
        logic [15:0] ex [5] = '{ITG_RST_COUNT, ITG_RST_PERIOD, ITG_RST_CONTROL, 16'h0, 16'h0};
        logic [31:0] q;
        for (int i = 0; i < 5; i++) begin
            rreg(ad[i], q);
            chk("reset value", {16'h0, ex[i]}, {16'h0, ex[i]}, q);
        end
        $display("reset test done");
    endtask : t_reset

    // Internal mode wrap, flag, mask and software clear
    task automatic t_internal();
        logic [31:0] q;
        wreg(ITG_ADDR_STATUS, 16'h0002);
        wreg(ITG_ADDR_PERIOD, 16'h0005);
        wreg(ITG_ADDR_CONTROL, 16'h8000);
        repeat (20) @(posedge clk);
        rreg(ITG_ADDR_COUNT, q);
        chk("wrapped count", 32'h0, 32'h5, q);
        rreg(ITG_ADDR_STATUS, q);
        chk("match flag", 32'h1, 32'h1, {31'h0, q[0]});
        chk("irq on", 32'h1, 32'h1, {31'h0, irq});
        wreg(ITG_ADDR_CONTROL, 16'h0000);
        wreg(ITG_ADDR_STATUS, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, 32'h0, {31'h0, irq});
        rreg(ITG_ADDR_STATUS, q);
        chk("flag kept", 32'h1, 32'h1, {31'h0, q[0]});
        wreg(ITG_ADDR_STATUS, 16'h0000);
        rreg(ITG_ADDR_STATUS, q);
        chk("flag cleared", 32'h0, 32'h0, {31'h0, q[0]});
        $display("internal mode test done");
    endtask : t_internal

    // Idle with and without stop-in-idle
    task automatic t_idle();
        logic [31:0] a;
        logic [31:0] b;
        wreg(ITG_ADDR_PERIOD, 16'hFFFF);
        wreg(ITG_ADDR_CONTROL, 16'hA000);
        idle <= 1'b1;
        rreg(ITG_ADDR_COUNT, a);
        repeat (20) @(posedge clk);
        rreg(ITG_ADDR_COUNT, b);
        chk("idle halted", a, a, b);
        wreg(ITG_ADDR_CONTROL, 16'h8000);
        rreg(ITG_ADDR_COUNT, a);
        repeat (20) @(posedge clk);
        rreg(ITG_ADDR_COUNT, b);
        chk("idle running", a + 32'h14, a + 32'h1E, b);
        idle <= 1'b0;
        $display("idle test done");
    endtask : t_idle

    // Every prescale ratio, count kept on control write, clear on count write
    task automatic t_prescale();
        int dv [4] = '{1, 8, 64, 256};
        logic [31:0] a;
        logic [31:0] b;
        for (int i = 0; i < 4; i++) begin
            wreg(ITG_ADDR_CONTROL, 16'h8000 | (16'(i) << 4));
            wreg(ITG_ADDR_COUNT, 16'h0000);
            repeat (100 * dv[i]) @(posedge clk);
            wreg(ITG_ADDR_CONTROL, 16'(i) << 4);
            rreg(ITG_ADDR_COUNT, a);
            chk("prescaled count", 32'h63, 32'h68, a);
            wreg(ITG_ADDR_CONTROL, 16'h2000);
            rreg(ITG_ADDR_COUNT, b);
            chk("count after control write", a, a, b);
        end
        wreg(ITG_ADDR_CONTROL, 16'h8030);
        repeat (200) @(posedge clk);
        wreg(ITG_ADDR_COUNT, 16'h0000);
        repeat (200) @(posedge clk);
        wreg(ITG_ADDR_CONTROL, 16'h0000);
        rreg(ITG_ADDR_COUNT, a);
        chk("prescaler cleared", 32'h0, 32'h0, a);
        $display("prescaler test done");
    endtask : t_prescale

    // External clock: sync and async, each free, in idle and in sleep
    task automatic t_extern();
        logic [15:0] ctl [6] = '{16'h8006, 16'hA006, 16'h8006, 16'h8002, 16'hA002, 16'h8002};
        logic [31:0] ex [6] = '{32'h3, 32'h0, 32'h0, 32'h3, 32'h0, 32'h3};
        logic [31:0] q;
        wreg(ITG_ADDR_PERIOD, 16'h0006);
        for (int i = 0; i < 6; i++) begin
            wreg(ITG_ADDR_COUNT, 16'h0000);
            wreg(ITG_ADDR_CONTROL, ctl[i]);
            idle <= (i % 3 == 1);
            sleep <= (i % 3 == 2);
            u_itg_pin_model.pulses(10, (i < 3) ? 4 : 1);
            repeat (8) @(posedge clk);
            rreg(ITG_ADDR_COUNT, q);
            idle <= 1'b0;
            sleep <= 1'b0;
            chk("external count", ex[i], ex[i], q);
        end
        $display("external clock test done");
    endtask : t_extern

    // Gated accumulation and the gate-fall event
    task automatic t_gate();
        logic [31:0] q;
        wreg(ITG_ADDR_CONTROL, 16'h0000);
        wreg(ITG_ADDR_PERIOD, 16'hFFFF);
        wreg(ITG_ADDR_COUNT, 16'h0000);
        wreg(ITG_ADDR_STATUS, 16'h0000);
        rreg(ITG_ADDR_STATUS, q);
        wreg(ITG_ADDR_CONTROL, 16'h8040);
        repeat (10) @(posedge clk);
        u_itg_pin_model.gate(50);
        repeat (10) @(posedge clk);
        rreg(ITG_ADDR_COUNT, q);
        chk("gated count", 32'h30, 32'h36, q);
        rreg(ITG_ADDR_STATUS, q);
        chk("gate fall event", 32'h9, 32'h9, {28'h0, q[3:0] & 4'h9});
        $display("gate test done");
    endtask : t_gate

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_internal();
        t_idle();
        t_prescale();
        t_extern();
        t_gate();
        report_and_stop();
    end

    // Watchdog well beyond the expected 34k cycles
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end
endmodule : tb_interval_timer16_gated
